/* File: src/misx_defines.svh */
`ifndef MISX_DEFINES_SVH
`define MISX_DEFINES_SVH

// Register byte offsets
`define MISX_OFF_CMD    8'h00
`define MISX_OFF_STATUS 8'h04
`define MISX_OFF_ACC    8'h08
`define MISX_OFF_PC     8'h0c
`define MISX_OFF_FPTR   8'h10
`define MISX_OFF_FDATA  8'h14
`define MISX_OFF_WAKE   8'h18

// Command word fields
`define MISX_CMD_OP     4:0
`define MISX_CMD_DEST   5
`define MISX_CMD_ARG    15:8
`define MISX_CMD_TGT    28:16

// Status word fields
`define MISX_ST_C       0
`define MISX_ST_DC      1
`define MISX_ST_Z       2
`define MISX_ST_PD      3
`define MISX_ST_GIE     4
`define MISX_ST_BUSY    8
`define MISX_ST_HALTED  9
`define MISX_ST_ASLEEP  10

// Wake register fields
`define MISX_WAKE_INT   0
`define MISX_WAKE_EXT   1

// Reset values and constants
`define MISX_PD_RST     1'b1
`define MISX_GIE_RST    1'b0
`define MISX_RESP_OKAY  2'h0
`define MISX_RESP_SLVERR 2'h2
`define MISX_ZERO8      8'h00

`endif

/* File: src/misx_pkg.sv */
`default_nettype none
package misx_pkg;
	// Execution states, one-hot
	typedef enum logic [3:0] {
		MISX_ST_IDLE  = 4'h1,
		MISX_ST_EXEC2 = 4'h2,
		MISX_ST_HALT  = 4'h4,
		MISX_ST_SLEEP = 4'h8
	} misx_state_t;

	// Instruction codes carried in the command word
	typedef enum logic [4:0] {
		MISX_OP_STORE     = 5'h00,
		MISX_OP_IRQ_RET   = 5'h01,
		MISX_OP_IDLE      = 5'h02,
		MISX_OP_RET_LIT   = 5'h03,
		MISX_OP_RET       = 5'h04,
		MISX_OP_RRF       = 5'h05,
		MISX_OP_RLF       = 5'h06,
		MISX_OP_HALT      = 5'h07,
		MISX_OP_SLEEP     = 5'h08,
		MISX_OP_LIT_MINUS = 5'h09,
		MISX_OP_FILE_MINUS  = 5'h0a,
		MISX_OP_FILE_MINUS_B = 5'h0b,
		MISX_OP_XOR_FILE  = 5'h0c,
		MISX_OP_XOR_LIT   = 5'h0d,
		MISX_OP_CALL      = 5'h0e
	} misx_op_t;
endpackage
`default_nettype wire

/* File: src/misx_alu.sv */
`default_nettype none
module misx_alu (
	input  wire misx_pkg::misx_op_t op,     // Instruction code
	input  wire logic [7:0]         acc,    // Accumulator
	input  wire logic [7:0]         opnd,   // File value or literal
	input  wire logic               c_in,   // Carry flag
	output logic      [7:0]         res,    // Result
	output logic                    c_out,  // New carry
	output logic                    dc_out  // New half-carry
);
	logic [8:0] sum;
	logic [4:0] half;
	logic       cin;

	// Subtraction as add of complement; carry set means no borrow
	always_comb begin
		cin = (op == misx_pkg::MISX_OP_FILE_MINUS_B) ? c_in : 1'b1;
		sum = {1'b0, opnd} + {1'b0, ~acc} + {8'h00, cin};
		half = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
		res = opnd;
		c_out = c_in;
		dc_out = half[4];
		case (op)
			misx_pkg::MISX_OP_LIT_MINUS, misx_pkg::MISX_OP_FILE_MINUS, misx_pkg::MISX_OP_FILE_MINUS_B: begin
				res = sum[7:0];
				c_out = sum[8];
			end
			misx_pkg::MISX_OP_RRF: begin
				res = {c_in, opnd[7:1]};
				c_out = opnd[0];
			end
			misx_pkg::MISX_OP_RLF: begin
				res = {opnd[6:0], c_in};
				c_out = opnd[7];
			end
			misx_pkg::MISX_OP_XOR_FILE, misx_pkg::MISX_OP_XOR_LIT: begin
				res = acc ^ opnd;
			end
			misx_pkg::MISX_OP_STORE: begin
				res = acc;
			end
			default: begin
				res = opnd;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: src/misx_core.sv */
// Notes on behaviour
// - Store copies accumulator to file, flags kept
// - Interrupt return pops stack, sets enable, two cycles
// - Idle changes nothing, one cycle
// - Literal return loads accumulator, pops, two cycles
// - Plain return pops stack, no flags, two cycles
// - Rotate right through carry, only carry changes
// - Rotate left through carry, carry and zero
// - Target bit selects accumulator or file register
// - Oscillator stop clears power flag, external wake
// - Literal minus accumulator, carry means no borrow
// - File minus accumulator to target, three flags
// - File minus accumulator minus inverted carry
// - Xor with file to target, zero only
// - Xor with literal to accumulator, zero only
// - Clock halt resumes on any wake source
// - Call pushes next address then jumps
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`include "misx_defines.svh"
`default_nettype none
module misx_core #(
	parameter int DEPTH = 8,   // Return stack depth
	parameter int PCW   = 13   // Program counter width
) (
	input  wire logic        aclk,          // Clock, 100 MHz
	input  wire logic        aresetn,       // Synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	output logic             core_halted,   // Core clock stopped
	output logic             osc_stopped    // Oscillator stopped
);
	localparam int SPW = $clog2(DEPTH);

	typedef struct packed {
		misx_pkg::misx_state_t       state;
		logic [7:0]                  acc;
		logic                        c;
		logic                        dc;
		logic                        z;
		logic                        pd;
		logic                        global_irq_enable;
		logic [PCW-1:0]              pc;
		logic [SPW-1:0]              sp;
		logic [DEPTH-1:0][PCW-1:0]   stk;
		logic [255:0][7:0]           mem;
		logic [7:0]                  fptr;
		logic                        aw_full;
		logic [7:0]                  aw_addr;
		logic                        w_full;
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
	} misx_regs_t;

	misx_regs_t             r_reg;
	misx_regs_t             r_next;
	misx_pkg::misx_op_t     op;
	logic [7:0]             arg;
	logic                   dest;
	logic [PCW-1:0]         tgt;
	logic [7:0]             opnd;
	logic [7:0]             res;
	logic                   c_new;
	logic                   dc_new;
	logic                   z_new;
	logic                   do_wr;
	logic                   exec;
	logic [PCW-1:0]         top_pc;
	logic [31:0]            wd;

	// Wrapping stack pointer step
	function automatic logic [SPW-1:0] sp_step(input logic [SPW-1:0] p, input logic up);
		if (up) begin
			return (p == SPW'(DEPTH - 1)) ? '0 : p + 1'b1;
		end
		return (p == '0) ? SPW'(DEPTH - 1) : p - 1'b1;
	endfunction

	// Byte-lane merge under write strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// Command fields and operand select
	assign op = misx_pkg::misx_op_t'(r_reg.w_data[`MISX_CMD_OP]);
	assign arg = r_reg.w_data[`MISX_CMD_ARG];
	assign dest = r_reg.w_data[`MISX_CMD_DEST];
	assign tgt = r_reg.w_data[`MISX_CMD_TGT];
	assign top_pc = r_reg.stk[sp_step(r_reg.sp, 1'b0)];
	assign opnd = (op == misx_pkg::MISX_OP_LIT_MINUS || op == misx_pkg::MISX_OP_XOR_LIT ||
		op == misx_pkg::MISX_OP_RET_LIT) ? arg : r_reg.mem[arg];
	assign z_new = (res == `MISX_ZERO8);
	assign wd = merge(32'h0000_0000, r_reg.w_data, r_reg.w_strb);

	misx_alu u_alu (
		.op     (op),
		.acc    (r_reg.acc),
		.opnd   (opnd),
		.c_in   (r_reg.c),
		.res    (res),
		.c_out  (c_new),
		.dc_out (dc_new)
	);

	// Bus handshakes and status outputs
	assign s_axi_awready = !r_reg.aw_full && !r_reg.bvalid;
	assign s_axi_wready = !r_reg.w_full && !r_reg.bvalid;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign core_halted = r_reg.state == misx_pkg::MISX_ST_HALT;
	assign osc_stopped = r_reg.state == misx_pkg::MISX_ST_SLEEP;
	assign do_wr = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;
	assign exec = do_wr && r_reg.aw_addr == `MISX_OFF_CMD && r_reg.state == misx_pkg::MISX_ST_IDLE;

	// Next-state logic: bus slave and instruction execution
	always_comb begin
		r_next = r_reg;
		if (r_reg.state == misx_pkg::MISX_ST_EXEC2) begin
			r_next.state = misx_pkg::MISX_ST_IDLE;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			r_next.aw_full = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			r_next.w_full = 1'b1;
			r_next.w_data = s_axi_wdata;
			r_next.w_strb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (do_wr) begin
			r_next.aw_full = 1'b0;
			r_next.w_full = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = `MISX_RESP_OKAY;
			case (r_reg.aw_addr)
				`MISX_OFF_CMD: begin
					if (!exec) begin
						r_next.bresp = `MISX_RESP_SLVERR;
					end
				end
				`MISX_OFF_STATUS: begin
					r_next.c = wd[`MISX_ST_C];
					r_next.dc = wd[`MISX_ST_DC];
					r_next.z = wd[`MISX_ST_Z];
					r_next.global_irq_enable = wd[`MISX_ST_GIE];
				end
				`MISX_OFF_ACC: begin
					r_next.acc = 8'(merge({24'h000000, r_reg.acc}, r_reg.w_data, r_reg.w_strb));
				end
				`MISX_OFF_FPTR: begin
					r_next.fptr = 8'(merge({24'h000000, r_reg.fptr}, r_reg.w_data, r_reg.w_strb));
				end
				`MISX_OFF_FDATA: begin
					r_next.mem[r_reg.fptr] = 8'(merge({24'h000000, r_reg.mem[r_reg.fptr]},
						r_reg.w_data, r_reg.w_strb));
				end
				`MISX_OFF_WAKE: begin
					if (r_reg.state == misx_pkg::MISX_ST_HALT && (wd[`MISX_WAKE_INT] || wd[`MISX_WAKE_EXT])) begin
						r_next.state = misx_pkg::MISX_ST_IDLE;
					end
					if (r_reg.state == misx_pkg::MISX_ST_SLEEP && wd[`MISX_WAKE_EXT]) begin
						r_next.state = misx_pkg::MISX_ST_IDLE;
					end
				end
				default: begin
					r_next.bresp = `MISX_RESP_SLVERR;
				end
			endcase
		end
		if (exec) begin
			r_next.pc = r_reg.pc + 1'b1;
			case (op)
				misx_pkg::MISX_OP_STORE: begin
					r_next.mem[arg] = r_reg.acc;
				end
				misx_pkg::MISX_OP_IDLE: begin
					r_next.acc = r_reg.acc;
				end
				misx_pkg::MISX_OP_RET, misx_pkg::MISX_OP_RET_LIT, misx_pkg::MISX_OP_IRQ_RET: begin
					r_next.pc = top_pc;
					r_next.sp = sp_step(r_reg.sp, 1'b0);
					r_next.state = misx_pkg::MISX_ST_EXEC2;
					if (op == misx_pkg::MISX_OP_RET_LIT) begin
						r_next.acc = arg;
					end
					if (op == misx_pkg::MISX_OP_IRQ_RET) begin
						r_next.global_irq_enable = 1'b1;
					end
				end
				misx_pkg::MISX_OP_CALL: begin
					r_next.stk[r_reg.sp] = r_reg.pc + 1'b1;
					r_next.sp = sp_step(r_reg.sp, 1'b1);
					r_next.pc = tgt;
					r_next.state = misx_pkg::MISX_ST_EXEC2;
				end
				misx_pkg::MISX_OP_HALT: begin
					r_next.state = misx_pkg::MISX_ST_HALT;
				end
				misx_pkg::MISX_OP_SLEEP: begin
					r_next.state = misx_pkg::MISX_ST_SLEEP;
					r_next.pd = 1'b0;
				end
				misx_pkg::MISX_OP_RRF, misx_pkg::MISX_OP_RLF, misx_pkg::MISX_OP_FILE_MINUS,
				misx_pkg::MISX_OP_FILE_MINUS_B, misx_pkg::MISX_OP_XOR_FILE: begin
					if (dest) begin
						r_next.mem[arg] = res;
					end else begin
						r_next.acc = res;
					end
					if (op != misx_pkg::MISX_OP_XOR_FILE) begin
						r_next.c = c_new;
					end
					if (op != misx_pkg::MISX_OP_RRF) begin
						r_next.z = z_new;
					end
					if (op == misx_pkg::MISX_OP_FILE_MINUS || op == misx_pkg::MISX_OP_FILE_MINUS_B) begin
						r_next.dc = dc_new;
					end
				end
				misx_pkg::MISX_OP_LIT_MINUS: begin
					r_next.acc = res;
					r_next.c = c_new;
					r_next.dc = dc_new;
					r_next.z = z_new;
				end
				misx_pkg::MISX_OP_XOR_LIT: begin
					r_next.acc = res;
					r_next.z = z_new;
				end
				default: begin
					r_next.pc = r_reg.pc;
					r_next.bresp = `MISX_RESP_SLVERR;
				end
			endcase
		end
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = `MISX_RESP_OKAY;
			r_next.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				`MISX_OFF_CMD: r_next.rdata = 32'h0000_0000;
				`MISX_OFF_STATUS: begin
					r_next.rdata[`MISX_ST_C] = r_reg.c;
					r_next.rdata[`MISX_ST_DC] = r_reg.dc;
					r_next.rdata[`MISX_ST_Z] = r_reg.z;
					r_next.rdata[`MISX_ST_PD] = r_reg.pd;
					r_next.rdata[`MISX_ST_GIE] = r_reg.global_irq_enable;
					r_next.rdata[`MISX_ST_BUSY] = r_reg.state != misx_pkg::MISX_ST_IDLE;
					r_next.rdata[`MISX_ST_HALTED] = r_reg.state == misx_pkg::MISX_ST_HALT;
					r_next.rdata[`MISX_ST_ASLEEP] = r_reg.state == misx_pkg::MISX_ST_SLEEP;
				end
				`MISX_OFF_ACC: r_next.rdata[7:0] = r_reg.acc;
				`MISX_OFF_PC: r_next.rdata[PCW-1:0] = r_reg.pc;
				`MISX_OFF_FPTR: r_next.rdata[7:0] = r_reg.fptr;
				`MISX_OFF_FDATA: r_next.rdata[7:0] = r_reg.mem[r_reg.fptr];
				`MISX_OFF_WAKE: r_next.rdata = 32'h0000_0000;
				default: r_next.rresp = `MISX_RESP_SLVERR;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
			r_reg.state <= misx_pkg::MISX_ST_IDLE;
			r_reg.pd <= `MISX_PD_RST;
			r_reg.global_irq_enable <= `MISX_GIE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Instruction checks
	store_keeps_flags_a: assert property (exec && op == misx_pkg::MISX_OP_STORE |=>
		r_reg.mem[$past(arg)] == $past(r_reg.acc) && $stable({r_reg.c, r_reg.dc, r_reg.z})
		&& r_reg.state == misx_pkg::MISX_ST_IDLE)
		else $error("store changed flags or missed file");
	irq_ret_two_a: assert property (exec && op == misx_pkg::MISX_OP_IRQ_RET |=>
		r_reg.global_irq_enable && r_reg.pc == $past(top_pc) && r_reg.state == misx_pkg::MISX_ST_EXEC2
		##1 r_reg.state == misx_pkg::MISX_ST_IDLE)
		else $error("interrupt return wrong");
	idle_no_change_a: assert property (exec && op == misx_pkg::MISX_OP_IDLE |=>
		$stable(r_reg.acc) && $stable({r_reg.c, r_reg.dc, r_reg.z, r_reg.sp})
		&& r_reg.pc == $past(r_reg.pc) + 1'b1)
		else $error("idle altered state");
	ret_lit_acc_a: assert property (exec && op == misx_pkg::MISX_OP_RET_LIT |=>
		r_reg.acc == $past(arg) && r_reg.sp == sp_step($past(r_reg.sp), 1'b0))
		else $error("literal return wrong");
	ret_keeps_flags_a: assert property (exec && op == misx_pkg::MISX_OP_RET |=>
		$stable({r_reg.c, r_reg.dc, r_reg.z}) && r_reg.pc == $past(top_pc))
		else $error("return wrong");
	rotate_right_a: assert property (exec && op == misx_pkg::MISX_OP_RRF && !dest |=>
		r_reg.acc == {$past(r_reg.c), $past(opnd[7:1])} && r_reg.c == $past(opnd[0]) && $stable(r_reg.z))
		else $error("rotate right wrong");
	rotate_left_a: assert property (exec && op == misx_pkg::MISX_OP_RLF |=>
		r_reg.c == $past(opnd[7]) && r_reg.z == ($past({opnd[6:0], r_reg.c}) == `MISX_ZERO8))
		else $error("rotate left flags wrong");
	sleep_stops_a: assert property (exec && op == misx_pkg::MISX_OP_SLEEP |=>
		!r_reg.pd && osc_stopped)
		else $error("sleep did not stop");
	sub_literal_a: assert property (exec && op == misx_pkg::MISX_OP_LIT_MINUS |=>
		r_reg.acc == 8'($past(arg) - $past(r_reg.acc)) && r_reg.c == ($past(arg) >= $past(r_reg.acc)))
		else $error("literal subtract wrong");
	xor_literal_a: assert property (exec && op == misx_pkg::MISX_OP_XOR_LIT |=>
		r_reg.acc == ($past(arg) ^ $past(r_reg.acc)) && $stable(r_reg.c))
		else $error("xor literal wrong");
	call_push_a: assert property (exec && op == misx_pkg::MISX_OP_CALL |=>
		top_pc == $past(r_reg.pc) + 1'b1 && r_reg.pc == $past(tgt))
		else $error("call push wrong");

	// Main scenarios
	cover_call_ret_c: cover property (exec && op == misx_pkg::MISX_OP_CALL ##[2:20]
		exec && op == misx_pkg::MISX_OP_RET);
	cover_halt_wake_c: cover property (core_halted ##[1:20] !core_halted);
	cover_sub_borrow_c: cover property (exec && op == misx_pkg::MISX_OP_FILE_MINUS_B && !r_reg.c);
endmodule
`default_nettype wire

/* File: verif/misx_core_test.sv */
`include "misx_defines.svh"
`default_nettype none
module misx_core_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk;
	logic        aresetn;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic        core_halted;
	logic        osc_stopped;
	int          failures;
	int          n_tests;
	int          cycles;
	logic [12:0] pc_exp;
	logic        pd_exp;

	misx_core #(.DEPTH(8), .PCW(13)) misx_core_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.core_halted(core_halted), .osc_stopped(osc_stopped)
	);

	// Clock, 100 MHz
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// Verdict and end of run
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Bus write: address and data together, each released when taken
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       aw_t;
		logic       w_t;
		logic       b_t;
		logic [1:0] resp;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Handshakes judged on settled values before the edge
		do begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
		end while (!b_t);
		s_axi_bready <= 1'b0;
		chk_resp("bresp", er, resp);
	endtask

	// Bus read with data and response check
	task automatic rd_chk(input logic [7:0] a, input string nm, input logic [31:0] exp, input logic [1:0] er);
		logic        ar_t;
		logic        r_t;
		logic [31:0] dat;
		logic [1:0]  resp;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// Data taken at the edge where rvalid and rready meet
		do begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			dat = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
		end while (!r_t);
		s_axi_rready <= 1'b0;
		chk_word(nm, exp, dat);
		chk_resp("rresp", er, resp);
	endtask

	task automatic exec(input logic [4:0] op, input logic d, input logic [7:0] arg, input logic [12:0] tgt,
		input logic [1:0] er);
		wr_chk(`MISX_OFF_CMD, {3'h0, tgt, arg, 2'h0, d, op}, er);
	endtask

	// Expected status word, flags as {z, dc, c}
	function automatic logic [31:0] st_word(input logic [2:0] fl, input logic global_irq_enable);
		return {27'h0, global_irq_enable, pd_exp, fl};
	endfunction

	// Expected {acc, file, z, dc, c} after one instruction
	function automatic logic [18:0] model(input misx_pkg::misx_op_t op, input logic d, input logic [7:0] a,
		input logic [7:0] f, input logic [7:0] k, input logic [2:0] fl);
		logic [8:0] t;
		logic [4:0] h;
		logic [7:0] r;
		logic [7:0] na;
		logic [7:0] nf;
		logic [7:0] o;
		logic [2:0] nfl;
		logic       b;
		nfl = fl;
		na = a;
		nf = f;
		r = 8'h00;
		o = (op == misx_pkg::MISX_OP_LIT_MINUS) ? k : f;
		b = (op == misx_pkg::MISX_OP_FILE_MINUS_B) ? !fl[0] : 1'b0;
		t = {1'b0, o} - {1'b0, a} - {8'h00, b};
		h = {1'b0, o[3:0]} - {1'b0, a[3:0]} - {4'h0, b};
		case (op)
			misx_pkg::MISX_OP_RRF: begin
				r = {fl[0], f[7:1]};
				nfl[0] = f[0];
			end
			misx_pkg::MISX_OP_RLF: begin
				r = {f[6:0], fl[0]};
				nfl = {r == 8'h00, fl[1], f[7]};
			end
			misx_pkg::MISX_OP_LIT_MINUS, misx_pkg::MISX_OP_FILE_MINUS, misx_pkg::MISX_OP_FILE_MINUS_B: begin
				r = t[7:0];
				nfl = {r == 8'h00, !h[4], !t[8]};
			end
			misx_pkg::MISX_OP_XOR_FILE, misx_pkg::MISX_OP_XOR_LIT: begin
				r = a ^ o;
				nfl[2] = (r == 8'h00);
			end
			default: ;
		endcase
		if (op == misx_pkg::MISX_OP_XOR_LIT)
			r = a ^ k;
		if (op == misx_pkg::MISX_OP_XOR_LIT)
			nfl[2] = (r == 8'h00);
		if (op == misx_pkg::MISX_OP_STORE)
			nf = a;
		else if (op == misx_pkg::MISX_OP_LIT_MINUS || op == misx_pkg::MISX_OP_XOR_LIT)
			na = r;
		else if (op != misx_pkg::MISX_OP_IDLE && d)
			nf = r;
		else if (op != misx_pkg::MISX_OP_IDLE)
			na = r;
		return {na, nf, nfl};
	endfunction

	// Main sequence
	initial begin
		misx_pkg::misx_op_t tbl [9];
		misx_pkg::misx_op_t op;
		logic [7:0]         a;
		logic [7:0]         f;
		logic [7:0]         k;
		logic [7:0]         fa;
		logic [2:0]         fl;
		logic               global_irq_enable;
		logic               d;
		logic [18:0]        m;
		logic [12:0]        ret0;
		tbl = '{misx_pkg::MISX_OP_STORE, misx_pkg::MISX_OP_IDLE, misx_pkg::MISX_OP_RRF, misx_pkg::MISX_OP_RLF,
			misx_pkg::MISX_OP_LIT_MINUS, misx_pkg::MISX_OP_FILE_MINUS, misx_pkg::MISX_OP_FILE_MINUS_B,
			misx_pkg::MISX_OP_XOR_FILE, misx_pkg::MISX_OP_XOR_LIT};
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		aresetn = 1'b0;
		failures = 0;
		n_tests = 0;
		cycles = 0;
		pc_exp = 13'h0000;
		pd_exp = 1'b1;
		void'($urandom(32'h2806247f));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset state and an unmapped read
		rd_chk(`MISX_OFF_STATUS, "status", st_word(3'h0, 1'b0), `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_PC, "pc", 32'h0, `MISX_RESP_OKAY);
		rd_chk(8'h1c, "unmapped", 32'h0, `MISX_RESP_SLVERR);
		// Random operands, every data instruction, with zero and borrow corners
		for (int i = 0; i < 63; i++) begin
			op = tbl[i % 9];
			a = 8'($urandom);
			f = 8'($urandom);
			k = 8'($urandom);
			fa = 8'($urandom);
			fl = 3'($urandom);
			global_irq_enable = 1'($urandom);
			d = 1'($urandom);
			if (i >= 27 && i < 36) begin
				f = a;
				k = a;
			end
			if (i >= 36 && i < 45) begin
				a = 8'hff;
				f = 8'h00;
				k = 8'h00;
			end
			wr_chk(`MISX_OFF_ACC, {24'h0, a}, `MISX_RESP_OKAY);
			wr_chk(`MISX_OFF_STATUS, {27'h0, global_irq_enable, 1'b0, fl}, `MISX_RESP_OKAY);
			wr_chk(`MISX_OFF_FPTR, {24'h0, fa}, `MISX_RESP_OKAY);
			wr_chk(`MISX_OFF_FDATA, {24'h0, f}, `MISX_RESP_OKAY);
			m = model(op, d, a, f, k, fl);
			exec(op, d, (op == misx_pkg::MISX_OP_LIT_MINUS || op == misx_pkg::MISX_OP_XOR_LIT) ? k : fa,
				13'h0, `MISX_RESP_OKAY);
			pc_exp++;
			rd_chk(`MISX_OFF_ACC, "acc", {24'h0, m[18:11]}, `MISX_RESP_OKAY);
			rd_chk(`MISX_OFF_FDATA, "file", {24'h0, m[10:3]}, `MISX_RESP_OKAY);
			rd_chk(`MISX_OFF_STATUS, "status", st_word(m[2:0], global_irq_enable), `MISX_RESP_OKAY);
			rd_chk(`MISX_OFF_PC, "pc", {19'h0, pc_exp}, `MISX_RESP_OKAY);
		end
		// Nested calls, literal return and plain return
		wr_chk(`MISX_OFF_STATUS, 32'h7, `MISX_RESP_OKAY);
		ret0 = pc_exp + 13'h1;
		exec(misx_pkg::MISX_OP_CALL, 1'b0, 8'h00, 13'h0123, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_PC, "pc", 32'h0123, `MISX_RESP_OKAY);
		exec(misx_pkg::MISX_OP_CALL, 1'b0, 8'h00, 13'h1fff, `MISX_RESP_OKAY);
		exec(misx_pkg::MISX_OP_RET_LIT, 1'b0, 8'h5a, 13'h0, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_ACC, "acc", 32'h5a, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_PC, "pc", 32'h0124, `MISX_RESP_OKAY);
		exec(misx_pkg::MISX_OP_RET, 1'b0, 8'h00, 13'h0, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_PC, "pc", {19'h0, ret0}, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_STATUS, "status", st_word(3'h7, 1'b0), `MISX_RESP_OKAY);
		// Call from the return address pushes the one after it
		exec(misx_pkg::MISX_OP_CALL, 1'b0, 8'h00, 13'h0777, `MISX_RESP_OKAY);
		exec(misx_pkg::MISX_OP_IRQ_RET, 1'b0, 8'h00, 13'h0, `MISX_RESP_OKAY);
		pc_exp = ret0 + 13'h1;
		rd_chk(`MISX_OFF_PC, "pc", {19'h0, pc_exp}, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_STATUS, "status", st_word(3'h7, 1'b1), `MISX_RESP_OKAY);
		// Clock halt, refusal while halted, wake by internal source
		exec(misx_pkg::MISX_OP_HALT, 1'b0, 8'h00, 13'h0, `MISX_RESP_OKAY);
		@(posedge aclk);
		chk_word("halted", 32'h1, {31'h0, core_halted});
		exec(misx_pkg::MISX_OP_IDLE, 1'b0, 8'h00, 13'h0, `MISX_RESP_SLVERR);
		wr_chk(`MISX_OFF_WAKE, 32'h1, `MISX_RESP_OKAY);
		@(posedge aclk);
		chk_word("halted", 32'h0, {31'h0, core_halted});
		exec(misx_pkg::MISX_OP_IDLE, 1'b0, 8'h00, 13'h0, `MISX_RESP_OKAY);
		rd_chk(`MISX_OFF_PC, "pc", {19'h0, pc_exp + 13'h2}, `MISX_RESP_OKAY);
		// Oscillator stop: power flag, busy and asleep bits, only external wake
		exec(misx_pkg::MISX_OP_SLEEP, 1'b0, 8'h00, 13'h0, `MISX_RESP_OKAY);
		pd_exp = 1'b0;
		rd_chk(`MISX_OFF_STATUS, "status", st_word(3'h7, 1'b1) | 32'h500, `MISX_RESP_OKAY);
		wr_chk(`MISX_OFF_WAKE, 32'h1, `MISX_RESP_OKAY);
		@(posedge aclk);
		chk_word("stopped", 32'h1, {31'h0, osc_stopped});
		wr_chk(`MISX_OFF_WAKE, 32'h2, `MISX_RESP_OKAY);
		@(posedge aclk);
		chk_word("stopped", 32'h0, {31'h0, osc_stopped});
		exec(misx_pkg::MISX_OP_IDLE, 1'b0, 8'h00, 13'h0, `MISX_RESP_OKAY);
		// Unknown code and unmapped write are refused
		exec(5'h1f, 1'b0, 8'h00, 13'h0, `MISX_RESP_SLVERR);
		rd_chk(`MISX_OFF_PC, "pc", {19'h0, pc_exp + 13'h4}, `MISX_RESP_OKAY);
		wr_chk(8'h1c, 32'h0, `MISX_RESP_SLVERR);
		conclude();
	end
endmodule
`default_nettype wire
